// >>> pkg/eep_defines.vh
// Purpose: Shared constants for the serial EEPROM slave front end
// Assumes: 10 MHz system clock
// Notes: Included by bare name
`ifndef EEP_DEFINES_VH
`define EEP_DEFINES_VH
`define EEP_MEM_DEPTH 16384
`define EEP_ADDR_W 14
`define EEP_TYPE_ID 4'ha
`define EEP_TYPE_MSB 7
`define EEP_TYPE_LSB 4
`define EEP_CE_MSB 3
`define EEP_CE_LSB 1
`define EEP_RW_BIT 0
`define EEP_CLK_NS 100
`define EEP_TW_NS 5000000
`define EEP_TW_CYC ((`EEP_TW_NS) / (`EEP_CLK_NS))
`endif

// >>> rtl/eep_sync2.v
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Synchronous active-high reset
// Notes: First stage is read only by the second
`timescale 1ns/100ps
module eep_sync2 #(
  parameter RST_VAL = 1'b1
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_async,
  output wire o_sync
);
  reg meta_ff;
  reg sync_ff;
  always @(posedge i_clock) begin
    if (i_rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end
  assign o_sync = sync_ff;
endmodule

// >>> rtl/eep_slave.v
// Purpose: Serial two-wire slave front end of a 16384 x 8 EEPROM
// Assumes: Bus master drives the serial clock; sampled by i_clock
// Notes: Open-drain data line given as input, output and output enable
// Contract
// - Storage of 16384 bytes, eight bits each, reached over the serial bus.
// - Respond only when the select byte upper nibble is 1010.
// - Acknowledge in the ninth slot after each master-written byte.
// - Select bits b3..b1 compared with high, mid, low strap inputs.
// - Floating strap inputs count as zero.
// - Write-inhibit high blocks change of any stored byte.
// - Floating write-inhibit counts as low, writes allowed.
// - Inhibited: ack select and address bytes, withhold data acks.
// - Held in standby ignoring the bus while reset is applied.
// - Reset reasserted drops everything at once.
// - Standby after Stop unless a programming cycle runs.
// - Start is data falling while clock high.
// - Outside programming, watch for Start; ignore bus until one.
// - Stop is data rising while clock high; ends the transaction.
// - Not-ack then Stop after a read byte returns to standby.
// - Stop right after a write data ack launches programming.
// - Transmitter releases data after eight bits; receiver acks ninth.
// - Data line only pulled low, otherwise released.
// - Select byte shifted MSB first, direction flag in b0.
// - Direction flag one reads, zero writes.
// - Strap mismatch gives no ack and deselects to standby.
// - Byte address sent high byte first, then low byte.
`timescale 1ns/100ps
`include "eep_defines.vh"
module eep_slave #(
  parameter DEPTH = `EEP_MEM_DEPTH,
  parameter AW = `EEP_ADDR_W,
  parameter TW_CYC = `EEP_TW_CYC
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda,
  output reg o_sda_oe,
  input wire i_chip_select_strap_low,
  input wire i_chip_select_strap_mid,
  input wire i_chip_select_strap_high,
  input wire i_write_inhibit_pin,
  output reg o_busy,
  output reg o_selected
);
  localparam S_IDLE = 7'h01;
  localparam S_DEV = 7'h02;
  localparam S_ADH = 7'h04;
  localparam S_ADL = 7'h08;
  localparam S_WDAT = 7'h10;
  localparam S_RDAT = 7'h20;
  localparam S_PROG = 7'h40;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling; floating straps and inhibit are pulled to zero externally
  wire scl_s;
  wire sda_s;
  wire wi_s;
  wire [2:0] ce_s;
  // Two flops per pin; the first stage may go metastable and feeds nothing else
  eep_sync2 #(.RST_VAL(1'b1)) u_scl (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_scl),
    .o_sync(scl_s)
  );
  eep_sync2 #(.RST_VAL(1'b1)) u_sda (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_sda),
    .o_sync(sda_s)
  );
  // Reset value zero matches an undriven inhibit pin
  eep_sync2 #(.RST_VAL(1'b0)) u_wi (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_write_inhibit_pin),
    .o_sync(wi_s)
  );

  wire [2:0] ce_raw;
  assign ce_raw = {i_chip_select_strap_high, i_chip_select_strap_mid, i_chip_select_strap_low};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ce
      eep_sync2 #(.RST_VAL(1'b0)) u_ce (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async(ce_raw[g]),
        .o_sync(ce_s[g])
      );
    end
  endgenerate

  reg scl_d_ff;
  reg sda_d_ff;
  always @(posedge i_clock) begin
    if (i_rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  function sel_match;
    input [7:0] b;
    input [2:0] ce;
    begin
      sel_match = (b[`EEP_TYPE_MSB:`EEP_TYPE_LSB] == `EEP_TYPE_ID) &&
        (b[`EEP_CE_MSB:`EEP_CE_LSB] == ce);
    end
  endfunction

  // Read bits go out by pulling the line, so a zero bit is a pull
  function pull_for;
    input b;
    begin
      pull_for = ~b;
    end
  endfunction

  function [AW-1:0] addr_next;
    input [AW-1:0] a;
    begin
      addr_next = a + 1'b1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage array
  reg [7:0] mem [0:DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  reg [6:0] state_ff;
  reg [3:0] bit_ff;
  reg [7:0] shift_ff;
  reg ack_slot_ff;
  reg ack_ok_ff;
  reg [AW-1:0] addr_ff;
  reg [7:0] wdata_ff;
  reg wpend_ff;
  reg arm_prog_ff;
  reg [31:0] tw_cnt_ff;
  reg master_nak_ff;

  always @(posedge i_clock) begin
    if (i_rst) begin
      state_ff <= S_IDLE;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      ack_slot_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      addr_ff <= {AW{1'b0}};
      wdata_ff <= 8'h00;
      wpend_ff <= 1'b0;
      arm_prog_ff <= 1'b0;
      tw_cnt_ff <= 32'h0;
      master_nak_ff <= 1'b0;
      o_sda_oe <= 1'b0;
      o_busy <= 1'b0;
      o_selected <= 1'b0;
    end else if (state_ff == S_PROG) begin
      o_sda_oe <= 1'b0;
      if (tw_cnt_ff == 32'h0) begin
        if (wpend_ff) begin
          mem[addr_ff] <= wdata_ff;
          addr_ff <= addr_next(addr_ff);
        end
        wpend_ff <= 1'b0;
        o_busy <= 1'b0;
        state_ff <= S_IDLE;
      end else begin
        tw_cnt_ff <= tw_cnt_ff - 32'h1;
      end
    end else if (stop_det) begin
      o_sda_oe <= 1'b0;
      o_selected <= 1'b0;
      bit_ff <= 4'h0;
      ack_slot_ff <= 1'b0;
      if (arm_prog_ff && state_ff == S_WDAT) begin
        state_ff <= S_PROG;
        tw_cnt_ff <= TW_CYC - 1;
        o_busy <= 1'b1;
      end else begin
        state_ff <= S_IDLE;
        wpend_ff <= 1'b0;
      end
      arm_prog_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= S_DEV;
      bit_ff <= 4'h0;
      ack_slot_ff <= 1'b0;
      arm_prog_ff <= 1'b0;
      wpend_ff <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (state_ff != S_IDLE) begin
      // While reading, the shifter holds outgoing bits; only the count moves
      if (scl_rise && !ack_slot_ff) begin
        if (state_ff != S_RDAT) begin
          shift_ff <= {shift_ff[6:0], sda_s};
        end
        bit_ff <= bit_ff + 4'h1;
      end
      if (scl_rise && ack_slot_ff && state_ff == S_RDAT) begin
        master_nak_ff <= sda_s;
      end
      if (scl_fall) begin
        if (ack_slot_ff) begin
          ack_slot_ff <= 1'b0;
          bit_ff <= 4'h0;
          o_sda_oe <= 1'b0;
          if (state_ff == S_RDAT) begin
            if (master_nak_ff) begin
              o_sda_oe <= 1'b0;
            end else begin
              o_sda_oe <= pull_for(mem[addr_ff][7]);
              shift_ff <= {mem[addr_ff][6:0], 1'b0};
              addr_ff <= addr_next(addr_ff);
            end
          end
          if (!ack_ok_ff) begin
            state_ff <= S_IDLE;
            o_selected <= 1'b0;
            o_sda_oe <= 1'b0;
          end
        end else if (state_ff == S_RDAT && bit_ff != 4'h8) begin
          o_sda_oe <= pull_for(shift_ff[7]);
          shift_ff <= {shift_ff[6:0], 1'b0};
        end else if (bit_ff == 4'h8) begin
          ack_slot_ff <= 1'b1;
          o_sda_oe <= 1'b0;
          ack_ok_ff <= 1'b1;
          case (state_ff)
            S_DEV: begin
              if (sel_match(shift_ff, ce_s)) begin
                o_sda_oe <= 1'b1;
                o_selected <= 1'b1;
                if (shift_ff[`EEP_RW_BIT]) begin
                  state_ff <= S_RDAT;
                  master_nak_ff <= 1'b0;
                end else begin
                  state_ff <= S_ADH;
                end
              end else begin
                ack_ok_ff <= 1'b0;
              end
            end
            S_ADH: begin
              addr_ff[AW-1:8] <= shift_ff[AW-9:0];
              o_sda_oe <= 1'b1;
              state_ff <= S_ADL;
            end
            S_ADL: begin
              addr_ff[7:0] <= shift_ff;
              o_sda_oe <= 1'b1;
              state_ff <= S_WDAT;
            end
            S_WDAT: begin
              if (!wi_s) begin
                o_sda_oe <= 1'b1;
                if (wpend_ff) begin
                  mem[addr_ff] <= wdata_ff;
                  addr_ff <= addr_next(addr_ff);
                end
                wdata_ff <= shift_ff;
                wpend_ff <= 1'b1;
                arm_prog_ff <= 1'b1;
              end
            end
            S_RDAT: begin
              ack_ok_ff <= 1'b1;
            end
            default: begin
              state_ff <= S_IDLE;
            end
          endcase
        end else begin
          // Disarm only once a bit after the ack completes; the rising clock
          // of a Stop must leave the write armed
          arm_prog_ff <= 1'b0;
        end
      end
      if (scl_fall && ack_slot_ff && state_ff == S_DEV) begin
        ack_slot_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin level register; held at zero so only the enable moves the wire
  always @(posedge i_clock) begin
    o_sda <= 1'b0;
  end
  // no clock is ever driven, the master owns timing
endmodule

// >>> verification/eep_slave_assertions.sv
// Purpose: Port checks for eep_slave
// Assumes: One clock domain
// Notes: Bind at the foot
`timescale 1ns/100ps
module eep_slave_assertions #(
  parameter TW_CYC = 20
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda,
  input wire o_sda_oe,
  input wire i_write_inhibit_pin,
  input wire o_busy,
  input wire o_selected
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  int cnt;
  // Counter, since a long repetition would stall the tools
  always @(posedge i_clock) cnt <= (i_rst || !o_busy) ? 0 : cnt + 1;
  sequence stop_cond;
    i_scl && $rose(i_sda);
  endsequence
  open_drain_a: assert property (!o_sda)
    else $error("data driven high");
  busy_quiet_a: assert property (o_busy |-> !o_sda_oe)
    else $error("line pulled while busy");
  reset_idle_a: assert property (disable iff (1'b0)
    i_rst |=> !o_sda_oe && !o_busy && !o_selected) else $error("not idle in reset");
  busy_length_a: assert property ($fell(o_busy) && !$past(i_rst) |-> cnt == TW_CYC)
    else $error("wrong busy length");
  stop_ends_a: assert property (stop_cond |-> ##[1:6] !o_selected)
    else $error("selected after stop");
  ack_edge_a: assert property ($changed(o_sda_oe) && !$past(i_rst) |-> !i_scl)
    else $error("data moved with clock high");
  write_start_a: assert property ($rose(o_busy) |-> i_scl && i_sda)
    else $error("busy without stop");
  inhibit_hold_a: assert property ($rose(o_busy) |-> !i_write_inhibit_pin)
    else $error("busy while inhibited");
endmodule
bind eep_slave eep_slave_assertions #(.TW_CYC(TW_CYC)) u_chk (.i_clock(i_clock),
  .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .i_write_inhibit_pin(i_write_inhibit_pin), .o_busy(o_busy), .o_selected(o_selected));

// >>> verification/eep_master_model.sv
// Purpose: Serial bus master model
// Assumes: Paced by the bench clock
// Notes: Clock stands high between frames
`timescale 1ns/100ps
module eep_master_model (
  input wire i_clock,
  input wire i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda_low = 1'b0
);
  task automatic wt(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    wt(4);
    o_scl = 1'b1;
    wt(2);
    r = i_sda;
    wt(2);
    o_scl = 1'b0;
  endtask
  task automatic start();
    // Long low phase lets a slave ack release before the clock rises
    o_sda_low = 1'b0;
    wt(4);
    o_scl = 1'b1;
    wt(4);
    o_sda_low = 1'b1;
    wt(4);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    wt(4);
    o_scl = 1'b1;
    wt(4);
    o_sda_low = 1'b0;
    wt(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(nak, a);
    ack = !a;
  endtask
endmodule

// >>> verification/eep_slave_tb_top.sv
// Purpose: Self-checking bench for eep_slave
// Assumes: 10 MHz clock, 800 ns serial clock
// Notes: Programming time cut to 200 cycles
`timescale 1ns/100ps
module eep_slave_tb_top;
  localparam int TW = 200;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] strap = 3'h0;
  logic inh = 1'b0;
  wire scl, sda_low, o_sda, o_sda_oe, o_busy, o_selected;
  // Pull-up: a released line reads high
  wire sda = !(sda_low || (o_sda_oe && !o_sda));
  int err_total = 0;
  int checked = 0;
  int seed = 46205;
  logic [7:0] mem [int];
  always #50 i_clock = ~i_clock;
  eep_master_model mst (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  eep_slave #(.TW_CYC(TW)) dut (.i_clock(i_clock), .i_rst(i_rst), .i_scl(scl),
    .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_chip_select_strap_low(strap[0]),
    .i_chip_select_strap_mid(strap[1]), .i_chip_select_strap_high(strap[2]),
    .i_write_inhibit_pin(inh), .o_busy(o_busy), .o_selected(o_selected));
  ////////////////////////////////////////
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic results();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 1000 && o_busy !== 1'b0; n++) @(negedge i_clock);
    if (n == 1000) begin
      err_total++;
      results();
    end
  endtask
  ////////////////////////////////////////
  task automatic txn(input logic [7:0] sel, input logic [15:0] a, input int nd, input logic rd);
    logic [7:0] q;
    logic ack;
    logic hit;
    hit = sel[7:4] == 4'ha && sel[3:1] == strap;
    mst.start();
    mst.xfer(sel, 1'b1, q, ack);
    cmp(ack, hit);
    if (hit) begin
      mst.xfer(a[15:8], 1'b1, q, ack);
      cmp(ack, 1'b1);
      mst.xfer(a[7:0], 1'b1, q, ack);
      cmp(ack, 1'b1);
      for (int j = 0; j < nd; j++) begin
        q = 8'(rnd());
        if (!inh) mem[(a + j) & 16'h3fff] = q;
        mst.xfer(q, 1'b1, q, ack);
        cmp(ack, !inh);
      end
      if (rd) begin
        mst.start();
        mst.xfer(sel | 8'h01, 1'b1, q, ack);
        cmp(ack, 1'b1);
        mst.xfer(8'hff, 1'b1, q, ack);
        if (mem.exists(a & 16'h3fff)) cmp(q, mem[a & 16'h3fff]);
      end
    end
    mst.stop();
    mst.wt(4);
    cmp(o_busy, hit && nd > 0 && !inh);
    if (o_busy === 1'b1) begin
      mst.start();
      mst.xfer(sel, 1'b1, q, ack);
      cmp(ack, 1'b0);
      mst.stop();
      wait_idle();
    end
  endtask
  initial begin
    logic [7:0] s;
    logic [15:0] a;
    logic ack;
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clock);
    for (int t = 0; t < 24; t++) begin
      strap = t == 0 ? 3'h0 : 3'(rnd());
      inh = t % 3 == 2;
      s = {4'ha, strap, 1'b0};
      if (t % 4 == 3) s[3:1] = ~strap;
      if (t % 8 == 5) s[7:4] = 4'h5;
      a = 16'(rnd()) & 16'hc00e;
      txn(s, a, 1 + t % 2, 1'b0);
      txn({4'ha, strap, 1'b0}, a, 0, 1'b1);
    end
    s = {4'ha, strap, 1'b0};
    mst.start();
    mst.xfer(s, 1'b1, a[7:0], ack);
    cmp(o_selected, 1'b1);
    i_rst = 1'b1;
    mst.xfer(8'h00, 1'b1, a[7:0], ack);
    cmp(ack, 1'b0);
    cmp(o_selected, 1'b0);
    mst.stop();
    i_rst = 1'b0;
    mst.wt(3);
    txn(s, 16'h0004, 1, 1'b0);
    txn(s, 16'h0004, 0, 1'b1);
    results();
  end
endmodule
